// >>> bench/cfgi2c_checker.sv
/*
  Checker of the link wires: ack slots, a quiet target, SDA hold while SCL high.
  Assumes one clock domain; only the host drives SCL.
*/
`timescale 1ns/1ps
`default_nettype none
module cfgi2c_checker (
   input wire logic       clk,
   input wire logic       reset,
   input wire logic       scl,
   input wire logic       sda,
   input wire logic       devSdaOut,
   input wire logic       devSdaOeN,
   input wire logic       bootDone,
   input wire logic [3:0] code
);
   logic       sclP, sdaP, first, foreign;
   logic [3:0] bitN;
   logic [7:0] sh, ctl;
   logic       rise, start, stop, ack, hit;
   // ============================================================
   // bus events
   assign rise  = scl & ~sclP;
   assign start = scl & sclP & sdaP & ~sda;
   assign stop  = scl & sclP & ~sdaP & sda;
   assign ack   = rise & (bitN == 4'h8);
   assign hit   = ctl[7:4] == code;
   // bit count, control byte and foreign transfers
   always_ff @(posedge clk) begin
      sclP <= scl;
      sdaP <= sda;
      if (reset | start | stop) begin
         bitN    <= 4'h0;
         first   <= start & ~reset;
         foreign <= 1'b0;
      end else if (ack) begin
         bitN    <= 4'h0;
         first   <= 1'b0;
         foreign <= foreign | (first & ~hit);
      end else if (rise) begin
         bitN <= bitN + 4'h1;
         sh   <= {sh[6:0], sda};
         if (first & (bitN == 4'h7)) ctl <= {sh[6:0], sda};
      end
   end
   // ============================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_boot_quiet: assert property (!bootDone |-> devSdaOeN)
      else $error("target drove sda before boot");
   a_boot_hold: assert property (bootDone |=> bootDone)
      else $error("boot done dropped");
   a_ctrl_ack: assert property (ack && first && hit && bootDone |-> !sda)
      else $error("control byte not acked");
   a_foreign_quiet: assert property ((ack && first && !hit) || foreign |-> devSdaOeN)
      else $error("target answered a foreign code");
   a_wdata_ack: assert property (ack && !first && hit && !ctl[0] |-> !sda)
      else $error("write byte not acked");
   a_wr_silent: assert property (rise && !ack && (first || !ctl[0]) |-> devSdaOeN)
      else $error("target drove a master bit");
   a_master_ack: assert property (ack && !first && ctl[0] |-> devSdaOeN)
      else $error("target held the master ack slot");
   a_high_stable: assert property (scl && sclP |-> $stable(devSdaOeN))
      else $error("target sda moved while scl high");
   a_open_drain: assert property (!devSdaOeN |-> !devSdaOut)
      else $error("target drove sda high");
endmodule
`default_nettype wire

// >>> bench/i2c_config_memory_target_port_tb_top.sv
/*
  Bench: host and target joined by the wire interface, run via the host port.
  Assumes the rtl files and the checker compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfgi2c_regs.svh"
module i2c_config_memory_target_port_tb_top;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0, rd = 1'b0, chkRd = 1'b0, chkD = 1'b0;
   logic [31:0] rdata, seed = 32'h0ab3;
   logic        busy, bootDone, protLocked, codePin0 = 1'b1;
   logic [15:0] macroIn = 16'h0;
   logic [63:0] expQ[$];
   logic [7:0]  dat[4];
   int          fail_count = 0;
   int          num_checks = 0;
   // ============================================================
   // design, wires and checker
   cfgi2c_if bus();
   cfgi2c_host cfgi2c_host_inst(.clk(clk), .reset(reset), .bus(bus), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .busy(busy));
   cfgi2c_device #(.CODE_FROM_PIN(4'h1)) cfgi2c_device_inst(.clk(clk), .reset(reset), .bus(bus),
      .ctrlCodePinBit0(codePin0), .ctrlCodePinBit1(1'b0), .ctrlCodePinBit2(1'b0), .ctrlCodePinBit3(1'b0),
      .macroIn(macroIn), .bootDone(bootDone), .protLocked(protLocked));
   cfgi2c_checker cfgi2c_checker_inst(.clk(clk), .reset(reset), .scl(bus.scl), .sda(bus.sda),
      .devSdaOut(bus.devSdaOut), .devSdaOeN(bus.devSdaOeN), .bootDone(bootDone), .code({3'h0, codePin0}));
   always #50 clk = ~clk;
   // ============================================================
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read; data stands at the edge after the strobe
   task automatic reg_rd(input logic [3:0] a, input logic c);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      chkRd <= c;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask
   // one byte-level command, polled to the end, status noted if masked
   task automatic op(input logic [2:0] o, input logic [7:0] b, input logic [31:0] e, input logic [31:0] m);
      int n;
      n = 0;
      reg_wr(`CFG_HOST_CMD, {21'h0, o, b});
      reg_rd(`CFG_HOST_STATUS, 1'b0);
      while (rdata[0] !== 1'b0 && n < 500) begin
         reg_rd(`CFG_HOST_STATUS, 1'b0);
         n++;
      end
      if (m != 0) begin
         expQ.push_back({m, e});
         reg_rd(`CFG_HOST_STATUS, 1'b1);
      end
   endtask
   task automatic st();
      op(`CFG_OP_START, 8'h0, 32'h0, 32'h0);
   endtask
   task automatic sp();
      op(`CFG_OP_STOP, 8'h0, 32'h0, 32'h0);
   endtask
   task automatic wb(input logic [7:0] b, input logic nk);
      op(`CFG_OP_WRITE, b, {30'h0, nk, 1'b0}, 32'h3);
   endtask
   task automatic rb(input logic [7:0] e, input logic last);
      op(last ? `CFG_OP_READ_NACK : `CFG_OP_READ_ACK, 8'h0, {16'h0, e, 8'h0}, 32'hff01);
   endtask
   task automatic ptr(input logic [2:0] k, input logic [7:0] w);
      st();
      wb({`CFG_CODE_DEFAULT, k, 1'b0}, 1'b0);
      wb(w, 1'b0);
   endtask
   task automatic wr1(input logic [2:0] k, input logic [7:0] w, input logic [7:0] d);
      ptr(k, w);
      wb(d, 1'b0);
      sp();
   endtask
   task automatic rd1(input logic [2:0] k, input logic [7:0] w, input logic [7:0] e);
      ptr(k, w);
      st();
      wb({`CFG_CODE_DEFAULT, k, 1'b1}, 1'b0);
      rb(e, 1'b1);
      sp();
   endtask
   // compare each flagged read with the oldest note
   always @(posedge clk) begin
      if (chkD) begin
         num_checks++;
         if ((rdata & expQ[0][63:32]) !== (expQ[0][31:0] & expQ[0][63:32])) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, rdata, expQ[0][31:0]);
         end
         void'(expQ.pop_front());
      end
      chkD <= rd & chkRd;
   end
   // watchdog
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      complete_run();
   end
   // ============================================================
   // scenarios
   initial begin
      seed = xs(seed);
      macroIn <= seed[15:0];
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 400 && bootDone !== 1'b1; i++) @(posedge clk);
      reg_wr(`CFG_HOST_DIV, 32'h1);
      expQ.push_back({32'hffff, 32'h1});
      reg_rd(`CFG_HOST_DIV, 1'b1);
      expQ.push_back({32'hffffffff, 32'h0});
      reg_rd(4'h7, 1'b1);
      // sequential write of four bytes from word 10
      ptr(3'h0, 8'h10);
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         dat[i] = seed[7:0];
         wb(dat[i], 1'b0);
      end
      sp();
      // random read across a repeated start, then current address read
      ptr(3'h0, 8'h10);
      st();
      wb({`CFG_CODE_DEFAULT, 3'h0, 1'b1}, 1'b0);
      rb(dat[0], 1'b0);
      rb(dat[1], 1'b0);
      rb(dat[2], 1'b1);
      sp();
      st();
      wb({`CFG_CODE_DEFAULT, 3'h0, 1'b1}, 1'b0);
      rb(dat[3], 1'b1);
      sp();
      // spaces: nonvolatile, block 001 alias, unused blocks, macrocells
      seed = xs(seed);
      wr1(`CFG_BLK_NVM, 8'h05, seed[7:0]);
      wr1(3'h1, 8'h20, seed[15:8]);
      rd1(3'h0, 8'h20, seed[15:8]);
      wr1(3'h3, 8'h05, ~seed[7:0]);
      for (int k = 3; k < 8; k++) rd1(k[2:0], 8'h05, `CFG_UNDEF_BYTE);
      rd1(`CFG_BLK_NVM, 8'h05, seed[7:0]);
      rd1(3'h0, `CFG_WORD_MACRO_LO, macroIn[7:0]);
      rd1(3'h0, `CFG_WORD_MACRO_HI, macroIn[15:8]);
      // foreign control code
      st();
      wb(8'h30, 1'b1);
      sp();
      // code bit 0 taken from its pin: old code refused, new one acked
      codePin0 <= 1'b0;
      st();
      wb({`CFG_CODE_DEFAULT, 4'h0}, 1'b1);
      sp();
      st();
      wb(8'h00, 1'b0);
      sp();
      codePin0 <= 1'b1;
      // protection, then the lock
      wr1(3'h0, `CFG_WORD_NPROT, 8'h02);
      wr1(`CFG_BLK_NVM, 8'h05, ~seed[7:0]);
      rd1(`CFG_BLK_NVM, 8'h05, seed[7:0]);
      rd1(3'h0, `CFG_WORD_NPROT, 8'h02);
      wr1(3'h0, `CFG_WORD_RPROT, 8'h01);
      rd1(3'h0, 8'h10, `CFG_UNDEF_BYTE);
      wr1(3'h0, `CFG_WORD_LOCK, 8'h01);
      num_checks++;
      if (protLocked !== 1'b1) begin
         fail_count++;
         $display("mismatch at %0t: lock flag not set", $time);
      end
      wr1(3'h0, `CFG_WORD_RPROT, 8'h00);
      rd1(3'h0, 8'h10, `CFG_UNDEF_BYTE);
      complete_run();
   end
endmodule
`default_nettype wire

// >>> rtl/cfgi2c_device.sv
/*
  Target-side I2C port of a configuration memory: control byte decode, byte
  and sequential writes, random, sequential and current-address reads over a
  volatile register space and a non-volatile space, with protection bytes.
  Assumes bus wires synchronous to clk and a master that does not stretch.
*/
//
// Functional notes
// - control code from parameter or pins
// - default control code is 0001
// - three block bits form pointer top
// - last control bit: 1 read, 0 write
// - acknowledge a valid control byte
// - 00x registers, 010 nonvolatile, others unused
// - master sends word address after write control
// - pointer is block bits over word address
// - acknowledge each write byte; master stops
// - commit write data at its acknowledge
// - sequential write increments pointer per byte
// - repeated start abandons write, keeps pointer
// - read control acked, then eight data bits
// - current read starts at stored pointer
// - master ack requests next read byte
// - protection bytes block space reads, writes
// - lock bit freezes both protection bytes
// - startup copies nonvolatile into volatile space
// - macrocell outputs readable as register bits
// - pointer increments at stop after command
// - master nacks last read byte then stops
`timescale 1ns/1ps
`default_nettype none
`include "cfgi2c_regs.svh"

module cfgi2c_device #(
   parameter logic [3:0] CODE_DEFAULT  = `CFG_CODE_DEFAULT,
   parameter logic [3:0] CODE_FROM_PIN = 4'h0,
   parameter int         MACRO_W       = 16
) (
   input  wire logic               clk,
   input  wire logic               reset,
   cfgi2c_if.dev                   bus,
   input  wire logic               ctrlCodePinBit0,
   input  wire logic               ctrlCodePinBit1,
   input  wire logic               ctrlCodePinBit2,
   input  wire logic               ctrlCodePinBit3,
   input  wire logic [MACRO_W-1:0] macroIn,
   output logic                    bootDone,
   output logic                    protLocked
);
   if (MACRO_W < 1 || MACRO_W > 16) begin : g_badWidth
      $error("MACRO_W must be 1 to 16");
   end

   cfgi2c_pkg::cfgi2c_dev_t q;
   cfgi2c_pkg::cfgi2c_dev_t d;
   logic [7:0]  ram [0:255];
   logic [7:0]  nvm [0:255];
   logic        ramWe;
   logic        nvmWe;
   logic [7:0]  wAddr;
   logic [7:0]  wData;
   logic [3:0]  ctrlCode;
   logic [15:0] macroWide;
   logic        rise;
   logic        fall;
   logic        startSeen;
   logic        stopSeen;
   logic [10:0] nextAddr;

   // ============================================================
   // bus events and configured identity
   assign ctrlCode = (CODE_FROM_PIN & {ctrlCodePinBit3, ctrlCodePinBit2, ctrlCodePinBit1, ctrlCodePinBit0})
                   | (~CODE_FROM_PIN & CODE_DEFAULT);
   assign macroWide = 16'(macroIn);
   assign rise = bus.scl & ~q.sclQ;
   assign fall = ~bus.scl & q.sclQ;
   assign startSeen = bus.scl & q.sclQ & q.sdaQ & ~bus.sda;
   assign stopSeen = bus.scl & q.sclQ & ~q.sdaQ & bus.sda;
   assign nextAddr = q.firstData ? q.ptr : q.ptr + 11'h001;

   // ============================================================
   // address decode and readback
   function automatic cfgi2c_pkg::cfgi2c_space_t spaceOf(input logic [2:0] blk);
      if (blk[2:1] == 2'b00) begin
         return cfgi2c_pkg::SP_RAM;
      end else if (blk == `CFG_BLK_NVM) begin
         return cfgi2c_pkg::SP_NVM;
      end
      return cfgi2c_pkg::SP_NONE;
   endfunction

   function automatic logic [7:0] readAt(input logic [10:0] a);
      logic [7:0] v;
      v = `CFG_UNDEF_BYTE;
      unique case (spaceOf(a[10:8]))
         cfgi2c_pkg::SP_RAM: begin
            if (!q.rprot[`CFG_PROT_RD_BIT]) begin
               unique case (a[7:0])
                  `CFG_WORD_RPROT:    v = q.rprot;
                  `CFG_WORD_NPROT:    v = q.nprot;
                  `CFG_WORD_LOCK:     v = {7'h00, q.lock};
                  `CFG_WORD_MACRO_LO: v = macroWide[7:0];
                  `CFG_WORD_MACRO_HI: v = macroWide[15:8];
                  default:            v = ram[a[7:0]];
               endcase
            end
         end
         cfgi2c_pkg::SP_NVM: begin
            if (!q.nprot[`CFG_PROT_RD_BIT]) begin
               v = nvm[a[7:0]];
            end
         end
         cfgi2c_pkg::SP_NONE: v = `CFG_UNDEF_BYTE;
      endcase
      return v;
   endfunction

   // ============================================================
   // next state of the bit and byte engine
   always_comb begin
      d = q;
      ramWe = 1'b0;
      nvmWe = 1'b0;
      wAddr = nextAddr[7:0];
      wData = q.shift;
      d.sclQ = bus.scl;
      d.sdaQ = bus.sda;
      if (q.st == cfgi2c_pkg::D_BOOT) begin
         ramWe = 1'b1;
         wAddr = q.bootIdx;
         wData = nvm[q.bootIdx];
         d.bootIdx = q.bootIdx + 8'h01;
         if (q.bootIdx == 8'hff) begin
            d.st = cfgi2c_pkg::D_IDLE;
            d.bootDone = 1'b1;
         end
      end else if (startSeen) begin
         d.st = cfgi2c_pkg::D_CTRL;
         d.cnt = 4'h0;
         d.sdaOeN = 1'b1;
      end else if (stopSeen) begin
         d.st = cfgi2c_pkg::D_IDLE;
         d.sdaOeN = 1'b1;
         d.incAtStop = 1'b0;
         if (q.incAtStop) begin
            d.ptr = q.ptr + 11'h001;
         end
      end else if (q.st != cfgi2c_pkg::D_IDLE && q.st != cfgi2c_pkg::D_IGNORE) begin
         if (rise) begin
            if (q.cnt < `CFG_ACK_SLOT) begin
               d.shift = {q.shift[6:0], bus.sda};
               d.cnt = q.cnt + 4'h1;
            end else if (q.cnt == `CFG_ACK_DONE && q.st == cfgi2c_pkg::D_READ) begin
               d.nack = bus.sda;
            end
         end else if (fall && q.st == cfgi2c_pkg::D_READ) begin
            if (q.cnt == `CFG_ACK_SLOT) begin
               d.sdaOeN = 1'b1;
               d.cnt = `CFG_ACK_DONE;
            end else if (q.cnt == `CFG_ACK_DONE) begin
               d.cnt = 4'h0;
               if (q.nack) begin
                  d.sdaOeN = 1'b1;
                  d.st = cfgi2c_pkg::D_IGNORE;
               end else begin
                  d.ptr = nextAddr;
                  d.firstData = 1'b0;
                  d.tx = readAt(nextAddr);
                  d.sdaOeN = d.tx[7];
               end
            end else if (q.cnt != 4'h0) begin
               d.sdaOeN = q.tx[3'(4'h7 - q.cnt)];
            end
         end else if (fall) begin
            if (q.cnt == `CFG_ACK_DONE) begin
               d.sdaOeN = 1'b1;
               d.cnt = 4'h0;
            end else if (q.cnt == `CFG_ACK_SLOT) begin
               d.cnt = `CFG_ACK_DONE;
               d.sdaOeN = 1'b0;
               unique case (q.st)
                  cfgi2c_pkg::D_CTRL: begin
                     if (q.shift[7:4] != ctrlCode) begin
                        d.sdaOeN = 1'b1;
                        d.st = cfgi2c_pkg::D_IGNORE;
                     end else begin
                        d.blk = q.shift[3:1];
                        d.incAtStop = 1'b1;
                        d.firstData = 1'b1;
                        if (q.shift[0]) begin
                           d.st = cfgi2c_pkg::D_READ;
                           d.ptr[10:8] = q.shift[3:1];
                           d.nack = 1'b0;
                        end else begin
                           d.st = cfgi2c_pkg::D_WORD;
                        end
                     end
                  end
                  cfgi2c_pkg::D_WORD: begin
                     d.ptr = {q.blk, q.shift};
                     d.st = cfgi2c_pkg::D_WDATA;
                  end
                  cfgi2c_pkg::D_WDATA: begin
                     d.ptr = nextAddr;
                     d.firstData = 1'b0;
                     unique case (spaceOf(nextAddr[10:8]))
                        cfgi2c_pkg::SP_RAM: begin
                           if (nextAddr[7:0] == `CFG_WORD_RPROT) begin
                              if (!q.lock) d.rprot = q.shift;
                           end else if (nextAddr[7:0] == `CFG_WORD_NPROT) begin
                              if (!q.lock) d.nprot = q.shift;
                           end else if (nextAddr[7:0] == `CFG_WORD_LOCK) begin
                              d.lock = q.lock | q.shift[0];
                           end else if (nextAddr[7:0] != `CFG_WORD_MACRO_LO
                                        && nextAddr[7:0] != `CFG_WORD_MACRO_HI) begin
                              ramWe = ~q.rprot[`CFG_PROT_WR_BIT];
                           end
                        end
                        cfgi2c_pkg::SP_NVM: nvmWe = ~q.nprot[`CFG_PROT_WR_BIT];
                        cfgi2c_pkg::SP_NONE: nvmWe = 1'b0;
                     endcase
                  end
                  default: d.st = cfgi2c_pkg::D_IGNORE;
               endcase
            end
         end
      end
   end

   // ============================================================
   // state register and memories; the nonvolatile array keeps its data
   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '0;
         q.st <= cfgi2c_pkg::D_BOOT;
         q.sclQ <= 1'b1;
         q.sdaQ <= 1'b1;
         q.sdaOeN <= 1'b1;
      end else begin
         q <= d;
      end
      if (ramWe) begin
         ram[wAddr] <= wData;
      end
      if (nvmWe) begin
         nvm[wAddr] <= wData;
      end
   end

   assign bootDone = q.bootDone;
   assign protLocked = q.lock;
   assign bus.devSdaOut = 1'b0;
   assign bus.devSdaOeN = q.sdaOeN;
endmodule

`default_nettype wire

// >>> rtl/cfgi2c_host.sv
/*
  I2C bus master: a byte-level engine driven by a plain register port.
  Software issues start, stop, byte write or byte read with ack or nack.
  Assumes the bus wires are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfgi2c_regs.svh"

module cfgi2c_host (
   input  wire logic        clk,
   input  wire logic        reset,
   cfgi2c_if.host           bus,
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   output logic             busy
);
   cfgi2c_pkg::cfgi2c_host_t q;
   cfgi2c_pkg::cfgi2c_host_t d;

   // ============================================================
   // next state: command port, divider and bit engine
   always_comb begin
      d = q;
      d.divCnt = (q.divCnt == 16'h0000) ? q.div : q.divCnt - 16'h0001;
      if (rd) begin
         unique case (addr)
            `CFG_HOST_STATUS: d.rdata = {16'h0000, q.rx, 6'h00, q.nack, q.busy};
            `CFG_HOST_DIV:    d.rdata = {16'h0000, q.div};
            default:          d.rdata = 32'h0000_0000;
         endcase
      end
      if (wr && addr == `CFG_HOST_DIV) begin
         d.div = (wdata[15:0] == 16'h0000) ? 16'h0001 : wdata[15:0];
      end
      // commands are dropped while a previous one is running
      if (wr && addr == `CFG_HOST_CMD && q.st == cfgi2c_pkg::H_IDLE) begin
         d.phase = 2'h0;
         d.bitN = 4'h0;
         d.sh = wdata[7:0];
         d.isRead = (wdata[10:8] == `CFG_OP_READ_ACK) || (wdata[10:8] == `CFG_OP_READ_NACK);
         d.ackRd = (wdata[10:8] == `CFG_OP_READ_ACK);
         if (wdata[10:8] == `CFG_OP_START) begin
            d.st = cfgi2c_pkg::H_START;
         end else if (wdata[10:8] == `CFG_OP_STOP) begin
            d.st = cfgi2c_pkg::H_STOP;
         end else if (wdata[10:8] == `CFG_OP_WRITE || d.isRead) begin
            d.st = cfgi2c_pkg::H_BIT;
         end
      end else if (q.divCnt == 16'h0000) begin
         d.phase = q.phase + 2'h1;
         unique case (q.st)
            cfgi2c_pkg::H_IDLE: d.phase = 2'h0;
            // release data, raise clock, pull data low while clock high
            cfgi2c_pkg::H_START: begin
               unique case (q.phase)
                  2'h0: d.sdaLow = 1'b0;
                  2'h1: d.sclLow = 1'b0;
                  2'h2: d.sdaLow = 1'b1;
                  2'h3: begin
                     d.sclLow = 1'b1;
                     d.st = cfgi2c_pkg::H_IDLE;
                  end
               endcase
            end
            // data low under a low clock, raise clock, then release data
            cfgi2c_pkg::H_STOP: begin
               unique case (q.phase)
                  2'h0: d.sdaLow = 1'b1;
                  2'h1: d.sclLow = 1'b0;
                  2'h2: d.sdaLow = 1'b0;
                  2'h3: d.st = cfgi2c_pkg::H_IDLE;
               endcase
            end
            // eight data bits then the acknowledge slot
            cfgi2c_pkg::H_BIT: begin
               unique case (q.phase)
                  2'h0: begin
                     if (q.bitN < `CFG_ACK_SLOT) begin
                        d.sdaLow = q.isRead ? 1'b0 : ~q.sh[7];
                     end else begin
                        d.sdaLow = q.isRead & q.ackRd;
                     end
                  end
                  2'h1: d.sclLow = 1'b0;
                  2'h2: begin
                     if (q.bitN < `CFG_ACK_SLOT) begin
                        if (q.isRead) begin
                           d.sh = {q.sh[6:0], bus.sda};
                        end
                     end else if (!q.isRead) begin
                        d.nack = bus.sda;
                     end
                  end
                  2'h3: begin
                     d.sclLow = 1'b1;
                     d.bitN = q.bitN + 4'h1;
                     if (q.bitN < `CFG_ACK_SLOT && !q.isRead) begin
                        d.sh = {q.sh[6:0], 1'b0};
                     end
                     if (q.bitN == `CFG_ACK_SLOT) begin
                        d.sdaLow = 1'b0;
                        d.st = cfgi2c_pkg::H_IDLE;
                        if (q.isRead) begin
                           d.rx = q.sh;
                        end
                     end
                  end
               endcase
            end
         endcase
      end
      d.busy = (d.st != cfgi2c_pkg::H_IDLE);
   end

   // ============================================================
   // state register
   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '0;
         q.st <= cfgi2c_pkg::H_IDLE;
         q.div <= 16'(`CFG_QUARTER_CYC - 1);
      end else begin
         q <= d;
      end
   end

   assign rdata = q.rdata;
   assign busy = q.busy;
   assign bus.hostSclOut = 1'b0;
   assign bus.hostSclOeN = ~q.sclLow;
   assign bus.hostSdaOut = 1'b0;
   assign bus.hostSdaOeN = ~q.sdaLow;
endmodule

`default_nettype wire

// >>> rtl/cfgi2c_if.sv
/*
  Open-drain I2C wires between the bus master and the configuration target.
  Each driver gives a value and an active-low enable; the wire level is the
  wired-AND worked out here. The target never drives the clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface cfgi2c_if;
   logic hostSclOut;
   logic hostSclOeN;
   logic hostSdaOut;
   logic hostSdaOeN;
   logic devSdaOut;
   logic devSdaOeN;
   logic scl;
   logic sda;

   // ============================================================
   // wired-and resolution, pulled up when nobody drives low
   assign scl = ~(~hostSclOeN & ~hostSclOut);
   assign sda = ~((~hostSdaOeN & ~hostSdaOut) | (~devSdaOeN & ~devSdaOut));

   modport host (output hostSclOut, output hostSclOeN, output hostSdaOut, output hostSdaOeN, input scl, input sda);
   modport dev  (output devSdaOut, output devSdaOeN, input scl, input sda);
endinterface

`default_nettype wire

// >>> rtl/cfgi2c_pkg.sv
/*
  Types shared by both ends of the configuration-memory I2C link.
  Assumes cfgi2c_regs.svh on the include path.
*/
`include "cfgi2c_regs.svh"

package cfgi2c_pkg;

   // ============================================================
   // target side
   typedef enum logic [2:0] {D_BOOT, D_IDLE, D_CTRL, D_WORD, D_WDATA, D_READ, D_IGNORE} cfgi2c_dstate_t;
   typedef enum logic [1:0] {SP_RAM, SP_NVM, SP_NONE} cfgi2c_space_t;

   typedef struct packed {
      cfgi2c_dstate_t st;
      logic [3:0]     cnt;
      logic [7:0]     shift;
      logic [7:0]     tx;
      logic [10:0]    ptr;
      logic [2:0]     blk;
      logic           firstData;
      logic           incAtStop;
      logic           nack;
      logic           sclQ;
      logic           sdaQ;
      logic           sdaOeN;
      logic [7:0]     rprot;
      logic [7:0]     nprot;
      logic           lock;
      logic [7:0]     bootIdx;
      logic           bootDone;
   } cfgi2c_dev_t;

   // ============================================================
   // host side
   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} cfgi2c_hstate_t;

   typedef struct packed {
      cfgi2c_hstate_t st;
      logic [1:0]     phase;
      logic [3:0]     bitN;
      logic [7:0]     sh;
      logic [7:0]     rx;
      logic           nack;
      logic           isRead;
      logic           ackRd;
      logic           sclLow;
      logic           sdaLow;
      logic [15:0]    div;
      logic [15:0]    divCnt;
      logic [31:0]    rdata;
      logic           busy;
   } cfgi2c_host_t;

endpackage

// >>> rtl/cfgi2c_regs.svh
/*
  Constants of the configuration-memory I2C port: control code, block codes,
  special word locations, host command port map and bus timing.
  Assumes inclusion by bare name from the package and both ends.
*/
`ifndef CFGI2C_REGS_SVH
`define CFGI2C_REGS_SVH

// ============================================================
// target addressing
`define CFG_CODE_DEFAULT   4'h1
`define CFG_BLK_NVM        3'h2
`define CFG_ACK_SLOT       4'h8
`define CFG_ACK_DONE       4'h9
`define CFG_UNDEF_BYTE     8'hff

// ============================================================
// special words inside the volatile register space
`define CFG_WORD_RPROT     8'he0
`define CFG_WORD_NPROT     8'he1
`define CFG_WORD_LOCK      8'he2
`define CFG_WORD_MACRO_LO  8'hf0
`define CFG_WORD_MACRO_HI  8'hf1
`define CFG_PROT_RD_BIT    0
`define CFG_PROT_WR_BIT    1

// ============================================================
// host command port
`define CFG_HOST_CMD       4'h0
`define CFG_HOST_STATUS    4'h1
`define CFG_HOST_DIV       4'h2
`define CFG_OP_START       3'h1
`define CFG_OP_STOP        3'h2
`define CFG_OP_WRITE       3'h3
`define CFG_OP_READ_ACK    3'h4
`define CFG_OP_READ_NACK   3'h5

// ============================================================
// timing: one quarter of a 100 kHz bus bit at a 100 ns clock
`define CFG_CLK_NS         100
`define CFG_QUARTER_NS     2500
`define CFG_QUARTER_CYC    ((`CFG_QUARTER_NS) / (`CFG_CLK_NS))

`endif
